/* File: rtl/lemc_hold_filter.sv */
// Level filter that reports an input only after it held high for N clocks
`timescale 1ns/100ps
`default_nettype none

module lemc_hold_filter #(
    parameter int N = 24
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic level_i,
    output logic      held_o
);

    localparam int CW = (N > 1) ? $clog2(N) : 1;
    localparam logic [CW-1:0] LAST = CW'(N - 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          held_reg;
    logic          held_next;

    // Count consecutive high clocks, clear the count and the held flag on low
    always_comb begin
        cnt_next  = '0;
        held_next = 1'b0;
        if (level_i) begin
            cnt_next  = (cnt_reg == LAST) ? cnt_reg : cnt_reg + CW'(1);
            held_next = (cnt_reg == LAST);
        end
    end

    // State registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= '0;
            held_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            held_reg <= held_next;
        end
    end

    assign held_o = held_reg;

endmodule // lemc_hold_filter

`default_nettype wire

/* File: rtl/lemc_top.sv */
// Lock decode, strap latch and in-circuit float mode with an Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none
`include "lemc_defines.svh"

module lemc_top (
    input  wire logic                      clk_i,
    input  wire logic                      resetn_i,
    input  wire lemc_pkg::lemc_addr_t      avs_address_i,
    input  wire logic                      avs_read_i,
    input  wire logic                      avs_write_i,
    input  wire lemc_pkg::lemc_data_t      avs_writedata_i,
    input  wire logic [3:0]                avs_byteenable_i,
    output lemc_pkg::lemc_data_t           avs_readdata_o,
    output logic                           avs_waitrequest_o,
    input  wire logic                      chip_rst_i,
    input  wire logic                      ext_access_select_i,
    input  wire logic                      addr_latch_strobe_i,
    input  wire logic                      code_read_strobe_i,
    input  wire logic                      lock_bit1_prog_i,
    input  wire logic                      lock_bit2_prog_i,
    input  wire lemc_pkg::lemc_code_addr_t fetch_addr_i,
    output logic                           ext_fetch_block_o,
    output logic                           code_prog_allow_o,
    output logic                           lock_prog_allow_o,
    output logic                           verify_allow_o,
    output logic                           fetch_internal_o,
    output logic                           ext_access_latched_o,
    output logic                           in_circuit_float_mode_o,
    output logic                           port0_oe_o,
    output logic                           port_weak_pull_o,
    output logic                           osc_run_o,
    output logic                           chip_reset_o
);
    import lemc_pkg::*;

    logic       sync1_reg;
    logic       sync2_reg;
    logic       rst_n;
    logic       in_reset;
    logic       release_now;
    lemc_lock_t lock_state;

    // Two-flop release of the asynchronous reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= 1'b1;
            sync2_reg <= sync1_reg;
        end
    end
    assign rst_n = sync2_reg;

    // Reset pin recognised after two machine cycles high
    lemc_hold_filter #(
        .N       (`LEMC_RST_CLKS)
    ) lemc_hold_filter_inst (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .level_i (chip_rst_i),
        .held_o  (in_reset)
    );

    assign release_now = in_reset && !chip_rst_i;
    assign lock_state  = lemc_lock_t'({lock_bit2_prog_i, lock_bit1_prog_i});

    // Protection decode
    logic blk_reg, blk_next, cpa_reg, cpa_next, lpa_reg, lpa_next, vfa_reg, vfa_next;
    always_comb begin
        blk_next = 1'b0;
        cpa_next = 1'b1;
        lpa_next = 1'b1;
        vfa_next = 1'b1;
        unique case (lock_state)
            LEMC_LOCK_NONE: begin
                blk_next = 1'b0;
            end
            LEMC_LOCK_L1: begin
                blk_next = 1'b1;
                cpa_next = 1'b0;
            end
            LEMC_LOCK_RSVD: begin
                blk_next = 1'b0;
            end
            LEMC_LOCK_FULL: begin
                blk_next = 1'b1;
                cpa_next = 1'b0;
                lpa_next = 1'b0;
                vfa_next = 1'b0;
            end
        endcase
    end

    // Strap latch, float mode and fetch select
    logic ea_reg, ea_next, arm_reg, arm_next, flt_reg, flt_next, fin_reg, fin_next;
    logic ea_eff;
    always_comb begin
        ea_next  = ea_reg;
        arm_next = 1'b0;
        flt_next = flt_reg;
        if (in_reset && lock_bit1_prog_i) begin
            ea_next = ext_access_select_i;
        end
        if (in_reset) begin
            arm_next = code_read_strobe_i && !addr_latch_strobe_i;
        end
        if (release_now) begin
            flt_next = arm_reg && !addr_latch_strobe_i;
        end
        ea_eff   = lock_bit1_prog_i ? ea_reg : ext_access_select_i;
        fin_next = (fetch_addr_i <= `LEMC_LOW_CODE_TOP) && ea_eff;
    end

    // Avalon slave: one wait cycle, then one ready cycle
    logic       wait_reg, wait_next, osc_stop_reg, osc_stop_next, req;
    lemc_data_t rd_reg, rd_next, status;
    always_comb begin
        status = '0;
        status[`LEMC_ST_LOCK1]     = lock_bit1_prog_i;
        status[`LEMC_ST_LOCK2]     = lock_bit2_prog_i;
        status[`LEMC_ST_EXT_BLOCK] = blk_reg;
        status[`LEMC_ST_CODE_PROG] = cpa_reg;
        status[`LEMC_ST_VERIFY]    = vfa_reg;
        status[`LEMC_ST_LOCK_PROG] = lpa_reg;
        status[`LEMC_ST_EA_LATCH]  = ea_reg;
        status[`LEMC_ST_FLOAT]     = flt_reg;
        status[`LEMC_ST_CHIP_RST]  = in_reset;
        req           = avs_read_i || avs_write_i;
        wait_next     = !(req && wait_reg);
        rd_next       = rd_reg;
        osc_stop_next = osc_stop_reg;
        if (avs_read_i && wait_reg) begin
            unique case (avs_address_i)
                `LEMC_STATUS_OFS: rd_next = status;
                `LEMC_CTRL_OFS:   rd_next = {31'h0000_0000, osc_stop_reg};
                default:          rd_next = `LEMC_RDATA_RST;
            endcase
        end
        if (avs_write_i && !wait_reg && avs_address_i == `LEMC_CTRL_OFS
            && avs_byteenable_i[0]) begin
            osc_stop_next = avs_writedata_i[`LEMC_CT_OSC_STOP];
        end
    end

    // State registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            blk_reg      <= 1'b0;
            cpa_reg      <= 1'b1;
            lpa_reg      <= 1'b1;
            vfa_reg      <= 1'b1;
            ea_reg       <= `LEMC_EA_LATCH_RST;
            arm_reg      <= 1'b0;
            flt_reg      <= 1'b0;
            fin_reg      <= 1'b0;
            wait_reg     <= 1'b1;
            rd_reg       <= `LEMC_RDATA_RST;
            osc_stop_reg <= `LEMC_CTRL_RST;
        end else begin
            blk_reg      <= blk_next;
            cpa_reg      <= cpa_next;
            lpa_reg      <= lpa_next;
            vfa_reg      <= vfa_next;
            ea_reg       <= ea_next;
            arm_reg      <= arm_next;
            flt_reg      <= flt_next;
            fin_reg      <= fin_next;
            wait_reg     <= wait_next;
            rd_reg       <= rd_next;
            osc_stop_reg <= osc_stop_next;
        end
    end

    // Pad control next values follow the float state and the oscillator stop bit, chip reset follows in_reset
    logic p0_reg, p0_next, pull_reg, pull_next, osc_reg, osc_next, crst_reg, crst_next;
    always_comb begin
        p0_next   = !flt_next;
        pull_next = flt_next;
        osc_next  = flt_next || !osc_stop_next;
        crst_next = in_reset;
    end

    // Pad control registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            p0_reg   <= 1'b1;
            pull_reg <= 1'b0;
            osc_reg  <= 1'b1;
            crst_reg <= 1'b0;
        end else begin
            p0_reg   <= p0_next;
            pull_reg <= pull_next;
            osc_reg  <= osc_next;
            crst_reg <= crst_next;
        end
    end

    assign ext_fetch_block_o       = blk_reg;
    assign code_prog_allow_o       = cpa_reg;
    assign lock_prog_allow_o       = lpa_reg;
    assign verify_allow_o          = vfa_reg;
    assign fetch_internal_o        = fin_reg;
    assign ext_access_latched_o    = ea_reg;
    assign in_circuit_float_mode_o = flt_reg;
    assign port0_oe_o              = p0_reg;
    assign port_weak_pull_o        = pull_reg;
    assign osc_run_o               = osc_reg;
    assign chip_reset_o            = crst_reg;
    assign avs_readdata_o          = rd_reg;
    assign avs_waitrequest_o       = wait_reg;

    // Checks
    sequence s_release;
        in_reset && !chip_rst_i;
    endsequence
    sequence s_enter;
        s_release ##0 arm_reg && !addr_latch_strobe_i;
    endsequence

    a_lock1_decode: assert property (@(posedge clk_i) disable iff (!rst_n)
        (lock_bit1_prog_i && !lock_bit2_prog_i) |=>
        (ext_fetch_block_o && !code_prog_allow_o && verify_allow_o))
        else $error("lock bit 1 decode wrong");
    a_full_lock: assert property (@(posedge clk_i) disable iff (!rst_n)
        (lock_bit1_prog_i && lock_bit2_prog_i) |=>
        (ext_fetch_block_o && !code_prog_allow_o && !verify_allow_o))
        else $error("full lock decode wrong");
    a_reserved_free: assert property (@(posedge clk_i) disable iff (!rst_n)
        !lock_bit1_prog_i |=> (!ext_fetch_block_o && code_prog_allow_o && verify_allow_o))
        else $error("unlocked or reserved code protects");
    a_strap_sample: assert property (@(posedge clk_i) disable iff (!rst_n)
        (in_reset && lock_bit1_prog_i) |=> ext_access_latched_o == $past(ext_access_select_i))
        else $error("strap not latched in reset");
    a_latch_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
        !in_reset |=> $stable(ext_access_latched_o))
        else $error("strap latch changed outside reset");
    a_float_enter: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_enter |=> in_circuit_float_mode_o ##1 (port_weak_pull_o && !port0_oe_o))
        else $error("float mode not entered");
    a_float_pads: assert property (@(posedge clk_i) disable iff (!rst_n)
        in_circuit_float_mode_o |-> (!port0_oe_o && port_weak_pull_o))
        else $error("port 0 driven in float mode");
    a_osc_float: assert property (@(posedge clk_i) disable iff (!rst_n)
        in_circuit_float_mode_o |-> osc_run_o)
        else $error("oscillator stopped in float mode");
    a_float_exit: assert property (@(posedge clk_i) disable iff (!rst_n)
        (s_release ##0 !arm_reg) |=> !in_circuit_float_mode_o[*2])
        else $error("float mode kept after plain reset");
    a_reset_held: assert property (@(posedge clk_i) disable iff (!rst_n)
        $rose(in_reset) |-> $past(chip_rst_i, 1) && $past(chip_rst_i, 23))
        else $error("reset recognised too early");
    a_low_fetch: assert property (@(posedge clk_i) disable iff (!rst_n)
        (!lock_bit1_prog_i && !ext_access_select_i) |=> !fetch_internal_o)
        else $error("low code fetch went internal");
    a_other_lock: assert property (@(posedge clk_i) disable iff (!rst_n)
        (lock_bit1_prog_i != lock_bit2_prog_i) |=> lock_prog_allow_o)
        else $error("other lock bit refused");

endmodule // lemc_top

`default_nettype wire

/* File: shared/lemc_defines.svh */
// Offsets, field positions, reset values and timing counts of the lock and float-mode block
`ifndef LEMC_DEFINES_SVH
`define LEMC_DEFINES_SVH

// Register byte offsets
`define LEMC_STATUS_OFS      4'h0
`define LEMC_CTRL_OFS        4'h4

// Status field positions
`define LEMC_ST_LOCK1        0
`define LEMC_ST_LOCK2        1
`define LEMC_ST_EXT_BLOCK    2
`define LEMC_ST_CODE_PROG    3
`define LEMC_ST_VERIFY       4
`define LEMC_ST_LOCK_PROG    5
`define LEMC_ST_EA_LATCH     6
`define LEMC_ST_FLOAT        7
`define LEMC_ST_CHIP_RST     8

// Control field positions and reset values
`define LEMC_CT_OSC_STOP     0
`define LEMC_CTRL_RST        1'b0
`define LEMC_EA_LATCH_RST    1'b1
`define LEMC_RDATA_RST       32'h0000_0000

// Reset recognition: two machine cycles of twelve oscillator clocks
`define LEMC_MC_CLKS         12
`define LEMC_RST_MC          2
`define LEMC_RST_CLKS        (`LEMC_MC_CLKS * `LEMC_RST_MC)

// Top of the low code region selected by the strap
`define LEMC_LOW_CODE_TOP    16'h0FFF

`endif

/* File: shared/lemc_pkg.sv */
// Types of the lock and float-mode block
package lemc_pkg;

    // Lock bit pair, bit 0 = lock bit 1, bit 1 = lock bit 2, 1 = programmed
    typedef enum logic [1:0] {
        LEMC_LOCK_NONE = 2'b00,
        LEMC_LOCK_L1   = 2'b01,
        LEMC_LOCK_RSVD = 2'b10,
        LEMC_LOCK_FULL = 2'b11
    } lemc_lock_t;

    typedef logic [3:0]  lemc_addr_t;
    typedef logic [31:0] lemc_data_t;
    typedef logic [15:0] lemc_code_addr_t;

endpackage

/* File: tb/lemc_board_model.sv */
// Board model: reset circuit, strap pin and emulator strobe control
`timescale 1ns/100ps
`default_nettype none

module lemc_board_model (
    input  wire logic       clk_i,
    input  wire logic       rst_req_i,
    input  wire logic [7:0] rst_len_i,
    input  wire logic       float_entry_i,
    input  wire logic       strap_i,
    output logic            chip_rst_o,
    output logic            ale_o,
    output logic            code_strobe_o,
    output logic            ext_sel_o,
    output logic            busy_o
);
    logic [8:0] cnt_reg = 9'h000;
    logic       ent_reg = 1'b0;

    // Reset pulse of rst_len_i cycles followed by three tail cycles
    always_ff @(posedge clk_i) begin
        if (rst_req_i && cnt_reg == 9'h000) begin
            cnt_reg <= {1'b0, rst_len_i} + 9'h003;
            ent_reg <= float_entry_i;
        end else if (cnt_reg != 9'h000) begin
            cnt_reg <= cnt_reg - 9'h001;
        end
    end

    // Reset pin high for the requested span
    assign chip_rst_o    = cnt_reg > 9'h003;
    // Strobe low through reset and past its release when float entry is requested
    assign ale_o         = !(ent_reg && cnt_reg != 9'h000);
    assign code_strobe_o = 1'b1;    // Code strobe idles high
    assign ext_sel_o     = strap_i; // Strap level from the bench
    assign busy_o        = cnt_reg != 9'h000;
endmodule // lemc_board_model
`default_nettype wire

/* File: tb/lemc_top_bench.sv */
// Self-checking bench of the lock decode, strap latch and float mode
`timescale 1ns/100ps
`default_nettype none
`include "lemc_defines.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end

module lemc_top_bench;
    import lemc_pkg::*;
    logic            clk_i = 1'b0, resetn_i = 1'b0;
    lemc_addr_t      avs_address_i = 4'h0;
    logic            avs_read_i = 1'b0, avs_write_i = 1'b0;
    lemc_data_t      avs_writedata_i = 32'h0000_0000, avs_readdata_o, rd;
    logic [3:0]      avs_byteenable_i = 4'hf;
    logic            avs_waitrequest_o, chip_rst_i, ext_access_select_i;
    logic            addr_latch_strobe_i, code_read_strobe_i;
    logic            lock_bit1_prog_i = 1'b0, lock_bit2_prog_i = 1'b0;
    lemc_code_addr_t fetch_addr_i = 16'h0000;
    logic            ext_fetch_block_o, code_prog_allow_o, lock_prog_allow_o;
    logic            verify_allow_o, fetch_internal_o, ext_access_latched_o;
    logic            in_circuit_float_mode_o, port0_oe_o, port_weak_pull_o;
    logic            osc_run_o, chip_reset_o, busy, seen = 1'b0;
    logic            rst_req = 1'b0, fent = 1'b0, strap = 1'b1;
    logic [7:0]      rst_len = 8'h1e;
    int              error_cnt = 0, total_checks = 0;

    lemc_top lemc_top_inst (.*);
    lemc_board_model lemc_board_model_inst (.clk_i(clk_i), .rst_req_i(rst_req),
        .rst_len_i(rst_len), .float_entry_i(fent), .strap_i(strap),
        .chip_rst_o(chip_rst_i), .ale_o(addr_latch_strobe_i),
        .code_strobe_o(code_read_strobe_i), .ext_sel_o(ext_access_select_i),
        .busy_o(busy));

    // Clock and recognised-reset flag
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (chip_reset_o === 1'b1) seen <= 1'b1;

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input lemc_addr_t a, input lemc_data_t wd,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i    <= a;
        avs_writedata_i  <= wd;
        avs_byteenable_i <= be;
        avs_read_i       <= !wr;
        avs_write_i      <= wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        `CHK("waitrequest", 1'b0, avs_waitrequest_o)
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    // Board reset of len cycles, with or without float entry
    task automatic board_rst(input logic [7:0] len, input logic ent);
        int n;
        n = 0;
        @(posedge clk_i);
        rst_len <= len;
        fent    <= ent;
        rst_req <= 1'b1;
        @(posedge clk_i);
        rst_req <= 1'b0;
        do begin
            @(negedge clk_i);
            n++;
        end while (busy !== 1'b0 && n < 400);
        `CHK("board_busy", 1'b0, busy)
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // Strap latch at power-up, at reset, and fetch routing
    task automatic t_strap();
        lock_bit1_prog_i <= 1'b1;
        strap            <= 1'b0;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("latch_powerup", 1'b1, ext_access_latched_o)
        seen <= 1'b0;
        board_rst(8'h1e, 1'b0);
        `CHK("reset_seen", 1'b1, seen)
        `CHK("latch_reset", 1'b0, ext_access_latched_o)
        bus(1'b0, `LEMC_STATUS_OFS, 32'h0000_0000, 4'hf);
        `CHK("status_latch", 1'b0, rd[6])
        @(posedge clk_i);
        strap        <= 1'b1;
        fetch_addr_i <= 16'h0100;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("latch_hold", 1'b0, ext_access_latched_o)
        `CHK("fetch_latched", 1'b0, fetch_internal_o)
        @(posedge clk_i);
        lock_bit1_prog_i <= 1'b0;
        fetch_addr_i     <= 16'h0fff;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("fetch_top_low", 1'b1, fetch_internal_o)
        @(posedge clk_i);
        fetch_addr_i <= 16'h1000;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("fetch_above", 1'b0, fetch_internal_o)
        $display("test strap done");
    endtask

    // All four lock bit combinations
    task automatic t_lock();
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_i);
            lock_bit1_prog_i <= c[0];
            lock_bit2_prog_i <= c[1];
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            `CHK("ext_block", c[0], ext_fetch_block_o)
            `CHK("code_prog", !c[0], code_prog_allow_o)
            `CHK("verify", c != 3, verify_allow_o)
            `CHK("lock_prog", c != 3, lock_prog_allow_o)
            bus(1'b0, `LEMC_STATUS_OFS, 32'h0000_0000, 4'hf);
            `CHK("status", {c != 3, c != 3, !c[0], c[0], c[1], c[0]}, rd[5:0])
        end
        lock_bit1_prog_i <= 1'b0;
        lock_bit2_prog_i <= 1'b0;
        $display("test lock_decode done");
    endtask

    // Float entry, oscillator hold, short reset, plain reset exit
    task automatic t_float();
        board_rst(8'h1e, 1'b1);
        `CHK("float_on", 1'b1, in_circuit_float_mode_o)
        `CHK("port0_oe", 1'b0, port0_oe_o)
        `CHK("weak_pull", 1'b1, port_weak_pull_o)
        bus(1'b1, `LEMC_CTRL_OFS, 32'h0000_0001, 4'hf);
        @(negedge clk_i);
        `CHK("osc_float", 1'b1, osc_run_o)
        seen <= 1'b0;
        board_rst(8'h0a, 1'b0);
        `CHK("short_seen", 1'b0, seen)
        `CHK("float_short", 1'b1, in_circuit_float_mode_o)
        board_rst(8'h1e, 1'b0);
        `CHK("float_off", 1'b0, in_circuit_float_mode_o)
        `CHK("port0_back", 1'b1, port0_oe_o)
        `CHK("weak_off", 1'b0, port_weak_pull_o)
        `CHK("osc_stop", 1'b0, osc_run_o)
        $display("test float_mode done");
    endtask

    // Byte enables, unmapped read and read-only status
    task automatic t_bus();
        bus(1'b1, `LEMC_CTRL_OFS, 32'h0000_0000, 4'h0);
        @(negedge clk_i);
        `CHK("ctrl_be_off", 1'b0, osc_run_o)
        bus(1'b1, `LEMC_CTRL_OFS, 32'h0000_0000, 4'h1);
        @(negedge clk_i);
        `CHK("ctrl_clear", 1'b1, osc_run_o)
        bus(1'b0, 4'h8, 32'h0000_0000, 4'hf);
        `CHK("unmapped", 32'h0000_0000, rd)
        bus(1'b1, `LEMC_STATUS_OFS, 32'hffff_ffff, 4'hf);
        bus(1'b0, `LEMC_STATUS_OFS, 32'h0000_0000, 4'hf);
        `CHK("status_ro", 6'h38, rd[5:0])
        `CHK("status_float", 1'b0, rd[7])
        $display("test register_bus done");
    endtask

    // Watchdog
    initial begin
        #100000;
        error_cnt++;
        $display("mismatch watchdog exp done got hang");
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        t_strap();
        t_lock();
        t_float();
        t_bus();
        wrap_up();
    end
endmodule // lemc_top_bench
`default_nettype wire
